//--- verilog/pwm_dac_pkg.sv
/*
  package for the pwm d/a output channel: register offsets, field positions,
  reset values and the control field struct. assumes an axi4-lite master with 32-bit data.
*/
`default_nettype none
package pwm_dac_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFF   = 4'h0;
  localparam logic [3:0] DUTY_OFF   = 4'h4;
  localparam logic [3:0] STATUS_OFF = 4'h8;
  // control field positions
  localparam int RES_SEL_BIT   = 0;
  localparam int PHASE_BIT     = 1;
  localparam int OUT_EN_BIT    = 2;
  localparam int CYC_LEN_BIT   = 3;
  // reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  DUTY_RST = 8'h00;
  // pulse counts per conversion cycle
  localparam logic [8:0]  PULSES_LONG  = 9'h100;
  localparam logic [8:0]  PULSES_SHORT = 9'h040;
  // axi responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        chan_a_out_en;
    logic        phase_invert_sel;
    logic        resolution_sel;
    logic        cycle_length_sel;
  } ctrl_s;
endpackage
`default_nettype wire

//--- verilog/pwm_dac_output.sv
/*
  pwm d/a output channel with axi4-lite register slave.
  assumes a single 50 mhz clock and synchronous active-low reset; the pin
  drives an external low-pass filter, so the low time per conversion cycle sets the level.
*/
// Register access over AXI4-Lite and the address map were decided locally.
// Operation
// [RULE1] pin drives waveform only when enable set
// [RULE2] phase bit zero direct, one inverted
// [RULE3] resolution bit selects one or two clocks
// [RULE4] total low time equals duty value
// [RULE5] cycle select gives 256 or 64 pulses
// [RULE6] inverted phase: duty equals total high time
// [RULE7] control bits reset to zero
// [RULE8] disabled pin holds low, counter keeps running
`timescale 1ns/10ps
`default_nettype none
module pwm_dac_output (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // pwm pin
  output logic             chan_a_pin
);
  pwm_dac_pkg::ctrl_s ctrl_r;
  logic [7:0]  duty_data_reg_r;
  logic        aw_hold_r;
  logic [3:0]  aw_addr_r;
  logic        w_hold_r;
  logic [31:0] w_data_r;
  logic        w_strb0_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        tick_r;
  logic [7:0]  pos_r;
  logic        cyc_start_r;
  logic        pin_r;

  // write channel: address and data taken in either order, response after both
  wire aw_take  = awvalid && !aw_hold_r && !bvalid_r;
  wire w_take   = wvalid && !w_hold_r && !bvalid_r;
  wire wr_go    = aw_hold_r && w_hold_r && !bvalid_r;
  wire wr_ctrl  = wr_go && (aw_addr_r == pwm_dac_pkg::CTRL_OFF);
  wire wr_duty  = wr_go && (aw_addr_r == pwm_dac_pkg::DUTY_OFF);
  wire wr_known = wr_ctrl || wr_duty;
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready  = !w_hold_r && !bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;

  wire [3:0] ctrl_bits = {ctrl_r.cycle_length_sel, ctrl_r.chan_a_out_en,
                          ctrl_r.phase_invert_sel, ctrl_r.resolution_sel};
  wire [31:0] rd_val =
    (araddr == pwm_dac_pkg::CTRL_OFF)   ? {28'h0000000, ctrl_bits} :
    (araddr == pwm_dac_pkg::DUTY_OFF)   ? {24'h000000, duty_data_reg_r} :
    (araddr == pwm_dac_pkg::STATUS_OFF) ? {23'h000000, pin_r, pos_r} : 32'h00000000;
  wire rd_known = (araddr == pwm_dac_pkg::CTRL_OFF) || (araddr == pwm_dac_pkg::DUTY_OFF)
                  || (araddr == pwm_dac_pkg::STATUS_OFF);
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h00000000;
      w_strb0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= pwm_dac_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {awaddr[3:2], 2'b00};
      end
      if (w_take) begin
        w_hold_r  <= 1'b1;
        w_data_r  <= wdata;
        w_strb0_r <= wstrb[0];
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_known ? pwm_dac_pkg::RESP_OKAY : pwm_dac_pkg::RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r          <= pwm_dac_pkg::ctrl_s'(pwm_dac_pkg::CTRL_RST[3:0]); // RULE7
      duty_data_reg_r <= pwm_dac_pkg::DUTY_RST;
    end else begin
      if (wr_ctrl && w_strb0_r) begin
        ctrl_r.resolution_sel   <= w_data_r[pwm_dac_pkg::RES_SEL_BIT];
        ctrl_r.phase_invert_sel <= w_data_r[pwm_dac_pkg::PHASE_BIT];
        ctrl_r.chan_a_out_en    <= w_data_r[pwm_dac_pkg::OUT_EN_BIT];
        ctrl_r.cycle_length_sel <= w_data_r[pwm_dac_pkg::CYC_LEN_BIT];
      end
      if (wr_duty && w_strb0_r) begin
        duty_data_reg_r <= w_data_r[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= pwm_dac_pkg::RESP_OKAY;
    end else if (arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_known ? pwm_dac_pkg::RESP_OKAY : pwm_dac_pkg::RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // resolution prescaler: every clock, or every second clock
  wire step = !ctrl_r.resolution_sel || tick_r; // RULE3
  // one unit per step; a cycle spans 256 or 64 units, low time = duty units in direct phase, high time when inverted
  wire [7:0] last_pos = ctrl_r.cycle_length_sel ? pwm_dac_pkg::PULSES_SHORT[7:0] - 8'h01
                                                : pwm_dac_pkg::PULSES_LONG[7:0] - 8'h01; // RULE5
  wire wrap = step && (pos_r >= last_pos);
  // short cycle saturates: values above 63 give a full-low cycle in direct phase, full-high when inverted
  wire raw_low = ({1'b0, pos_r} < {1'b0, duty_data_reg_r}); // RULE4
  wire shaped  = ctrl_r.phase_invert_sel ? raw_low : !raw_low; // RULE2 RULE6
  wire pin_nxt = ctrl_r.chan_a_out_en ? shaped : 1'b0; // RULE1 RULE8

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_r      <= 1'b0;
      pos_r       <= 8'h00;
      cyc_start_r <= 1'b0;
      pin_r       <= 1'b0;
    end else begin
      tick_r      <= ctrl_r.resolution_sel ? !tick_r : 1'b0;
      pos_r       <= wrap ? 8'h00 : (step ? pos_r + 8'h01 : pos_r); // RULE8
      cyc_start_r <= wrap;
      pin_r       <= pin_nxt;
    end
  end
  assign chan_a_pin = pin_r;

  // checks
  property pin_off_p;
    @(posedge aclk) disable iff (!aresetn) !ctrl_r.chan_a_out_en |=> !chan_a_pin;
  endproperty
  pin_disabled_a: assert property (pin_off_p) else $error("pin active while disabled"); // RULE1
  phase_direct_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
    ctrl_r.chan_a_out_en && !ctrl_r.phase_invert_sel && (pos_r < duty_data_reg_r) |=> !chan_a_pin)
    else $error("direct phase not low in duty window");
  phase_invert_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
    ctrl_r.chan_a_out_en && ctrl_r.phase_invert_sel && (pos_r < duty_data_reg_r) |=> chan_a_pin)
    else $error("inverted phase not high in duty window");
  sequence two_clk_s;
    ctrl_r.resolution_sel && step ##1 ctrl_r.resolution_sel;
  endsequence
  half_rate_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    two_clk_s |-> !step) else $error("two-clock resolution stepped twice");
  full_rate_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    !ctrl_r.resolution_sel |-> step) else $error("one-clock resolution missed a step");
  short_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
    ctrl_r.cycle_length_sel && step && pos_r == 8'h3F |=> pos_r == 8'h00)
    else $error("short cycle did not wrap at 64");
  long_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
    !ctrl_r.cycle_length_sel && step && pos_r == 8'hFF |=> pos_r == 8'h00 && cyc_start_r)
    else $error("long cycle did not wrap at 256");
  duty_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
    ctrl_r.chan_a_out_en && !ctrl_r.phase_invert_sel && $stable(ctrl_r) && (pos_r >= duty_data_reg_r)
    |=> chan_a_pin) else $error("low outside duty window");
  reset_ctrl_a: assert property (@(posedge aclk) !aresetn |=> ctrl_bits == 4'h0 && !chan_a_pin) // RULE7
    else $error("control not cleared by reset");

  // parked pin: the position keeps running, so a re-enable picks up
  // mid-cycle instead of restarting the conversion
  sequence parked_step_s;
    !ctrl_r.chan_a_out_en && step && !wrap;
  endsequence
  count_free_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
    parked_step_s |=> pos_r == $past(pos_r) + 8'h01)
    else $error("position stalled while disabled");
  invert_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
    ctrl_r.chan_a_out_en && ctrl_r.phase_invert_sel && (pos_r >= duty_data_reg_r) |=> !chan_a_pin)
    else $error("inverted phase high outside duty window");
  // response only once both halves are held; no new write is taken meanwhile
  resp_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> bvalid && !awready && !wready)
    else $error("write response not raised after address and data");
endmodule
`default_nettype wire

//--- sim/pwm_load_model.sv
/*
  load model for the pwm pin: integrates time spent low and high.
  assumes the pin is sampled on aclk, as a filter would average it.
*/
`timescale 1ns/10ps
`default_nettype none
module pwm_load_model (
  // clock
  input  wire logic aclk,
  // measurement restart
  input  wire logic clr,
  // pin under load
  input  wire logic chan_a_pin,
  // integrated times in clocks
  output var int    low_cnt,
  output var int    high_cnt
);
  // a filter sees only total time per level, so counting is enough
  always @(posedge aclk) begin
    if (clr) begin
      low_cnt  <= 0;
      high_cnt <= 0;
    end else if (chan_a_pin === 1'b1) begin
      high_cnt <= high_cnt + 1;
    end else if (chan_a_pin === 1'b0) begin
      low_cnt <= low_cnt + 1;
    end
  end
endmodule
`default_nettype wire

//--- sim/pwm_dac_output_tb_top.sv
/*
  testbench for the pwm d/a channel: axi4-lite tasks and pin measurements.
  assumes the load model integrates the pin over whole conversion cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module pwm_dac_output_tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, clr;
  logic        awready, wready, bvalid, arready, rvalid, chan_a_pin, a_t, w_t, v;
  logic [3:0]  awaddr, araddr, wstrb, ws;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  int          low_cnt, high_cnt, error_cnt, tests_run, cyc;

  pwm_dac_output u_pwm_dac_output (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .chan_a_pin(chan_a_pin));
  pwm_load_model u_pwm_load_model (.aclk(aclk), .clr(clr), .chan_a_pin(chan_a_pin),
    .low_cnt(low_cnt), .high_cnt(high_cnt));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // the whole run is about 4500 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      end_sim;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is sampled at the falling edge so the taking edge is known without a race
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= ws; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge aclk); a_t = awvalid && awready; w_t = wvalid && wready;
      @(posedge aclk); if (a_t) awvalid <= 1'b0; if (w_t) wvalid <= 1'b0;
    end while (awvalid && !a_t || wvalid && !w_t);
    do begin @(negedge aclk); v = bvalid; rs = bresp; @(posedge aclk); end while (!v);
    bready <= 1'b0;
  endtask

  task rd_reg(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin @(negedge aclk); a_t = arready; @(posedge aclk); end while (!a_t);
    arvalid <= 1'b0;
    while (!rvalid) @(negedge aclk);
    rd = rdata; rs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task meas(input logic [31:0] ctrl, input logic [31:0] duty, input int n);
    wr(pwm_dac_pkg::DUTY_OFF, duty);
    wr(pwm_dac_pkg::CTRL_OFF, ctrl);
    repeat (600) @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    clr = 1'b0; awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0; wdata = 32'h0; cyc = 0;
    error_cnt = 0; tests_run = 0; ws = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(pwm_dac_pkg::CTRL_OFF); chk(rd, 32'h0);
    chk({31'h0, chan_a_pin}, 32'h0);
    rd_reg(4'hC); chk({30'h0, rs}, {30'h0, pwm_dac_pkg::RESP_SLVERR});
    meas(32'h4, 32'h40, 256); chk(low_cnt, 32'h40);
    chk(high_cnt, 32'hC0);
    meas(32'h6, 32'h40, 256); chk(high_cnt, 32'h40);
    chk(low_cnt, 32'hC0);
    meas(32'h5, 32'h40, 512); chk(low_cnt, 32'h80);
    meas(32'hC, 32'h10, 64); chk(low_cnt, 32'h10);
    meas(32'h2, 32'h40, 256); chk(high_cnt, 32'h0);
    chk(low_cnt, 32'h100);
    rd_reg(pwm_dac_pkg::CTRL_OFF); chk(rd, 32'h2);
    // lane 0 masked: the control register must not move
    ws = 4'hE;
    wr(pwm_dac_pkg::CTRL_OFF, 32'hF);
    ws = 4'hF;
    rd_reg(pwm_dac_pkg::CTRL_OFF); chk(rd, 32'h2);
    wr(4'hC, 32'hF); chk({30'h0, rs}, {30'h0, pwm_dac_pkg::RESP_SLVERR});
    wr(pwm_dac_pkg::CTRL_OFF, 32'hF); chk({30'h0, rs}, {30'h0, pwm_dac_pkg::RESP_OKAY});
    // short cycle with duty above 63 saturates: inverted pin stays high
    repeat (4) @(posedge aclk);
    chk({31'h0, chan_a_pin}, 32'h1);
    // reset in mid-run with everything enabled
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(pwm_dac_pkg::CTRL_OFF); chk(rd, 32'h0);
    chk({31'h0, chan_a_pin}, 32'h0);
    rd_reg(pwm_dac_pkg::STATUS_OFF); chk({8'h0, rd[31:8]}, 32'h0);
    rd_reg(pwm_dac_pkg::DUTY_OFF); chk(rd, 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire
